// ### hw/pertm_pkg.sv
// Constants for the periodic interrupt timer: register map, field positions,
// reset values and prescaler settings.
// Assumes one 32-bit AHB-Lite slave port and a 200 MHz system clock.
package pertm_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CTL = 32'h8007FC40;
  localparam logic [31:0] ADDR_CNT = 32'h8007FC44;
  localparam logic [31:0] ADDR_ISTS = 32'h8007FC60;
  localparam logic [31:0] ADDR_IEN = 32'h8007FC64;
  localparam logic [31:0] ADDR_ICLR = 32'h8007FC68;

  // Control word fields; bit 0 of the big-endian numbering is bit 31 here
  localparam int CTL_RUN_BIT = 30;
  localparam int CTL_IE_BIT = 29;
  localparam int CTL_PS_MSB = 26;
  localparam int CTL_PS_LSB = 24;
  localparam int CTL_STS_BIT = 16;
  localparam int CTL_RLD_MSB = 15;
  localparam int CTL_RLD_LSB = 0;

  // Interrupt event bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_NUM = 2;

  // Reset values
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [2:0] RST_PSEL = 3'h0;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_IE = 1'b0;
  localparam logic [1:0] RST_IEN = 2'h0;

  // Prescaler: divide input edges by 4, 8, 16, 32 or 64
  localparam int PSC_W = 6;
  localparam logic [2:0] PSEL_MAX = 3'h4;
  localparam logic [PSC_W-1:0] PSC_DIV4_LAST = 6'h03;

  // Input pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [0:0] {
    PERTM_BUS_IDLE = 1'b0,
    PERTM_BUS_WWAIT = 1'b1
  } pertm_bus_st_t;

endpackage

// ### hw/pertm_prescaler.sv
// Prescaler for the periodic interrupt timer: counts input clock edges and
// emits one tick per 4, 8, 16, 32 or 64 edges.
// Assumes in_edge is a one-cycle pulse on clk; restart realigns the phase.
`timescale 1ns/1ps
module pertm_prescaler
  import pertm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic in_edge, // One input clock edge
  input wire logic en, // Count only while running
  input wire logic restart, // Clear the phase
  input wire logic [2:0] psel, // Prescale select code
  output logic tick // One prescaled tick
);

  logic [PSC_W-1:0] cnt_q;
  logic [PSC_W-1:0] cnt_d;
  logic [PSC_W-1:0] last;
  logic psel_ok;
  logic at_last;

  // Divisor is 4 << psel; reserved codes give no ticks at all
  assign psel_ok = psel <= PSEL_MAX;
  assign last = psel_ok ? PSC_W'((PSC_DIV4_LAST + 6'h01) << psel) - 6'h01 : '1;
  assign at_last = cnt_q == last;
  assign tick = en & in_edge & psel_ok & at_last & ~restart;

  always_comb begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = '0;
    end else if (en && in_edge) begin
      cnt_d = (at_last || cnt_q > last) ? '0 : cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ### hw/pertm_top.sv
// Periodic interrupt timer: 16-bit modulus down-counter fed by a selectable
// prescaler, with control, live count and interrupt registers on AHB-Lite.
// Assumes the timer input clock arrives on crystal_input, far slower than clk,
// and that only whole-word single transfers are made.
// Function
// - Counter is 16 bits, decremented by the prescaled input clock.
// - Prescale codes 0 to 4 divide by 4 to 64; others reserved.
// - After loading, counter decrements toward zero on every prescaled tick.
// - Zero sets the status flag; request raised only with interrupt enable.
// - Next input clock edge after zero reloads the counter and restarts.
// - Writing the reload count aborts countdown and loads the value at once.
// - Request stays asserted while the status flag remains set.
// - Zero reached again with flag set keeps one pending request only.
// - Reload count of zero gives a full 65536-tick period.
// - Run enable clear stops decrementing and holds the count.
// - Reading the live count leaves counter and countdown untouched.
// - Writing one to the flag is ignored; zero after read-one clears.
// - Interrupt enable clear only masks requests; counting goes on.
// - Control layout: run bit1, irq enable bit2, prescale 5-7, flag 15, reload 16-31.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module pertm_top
  import pertm_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB transfer size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [1:0] hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic crystal_input, // Timer input clock from the clock module
  output logic timer_irq_req, // Request to the interrupt controller
  output logic irq // Level interrupt from the event registers
);

  // Bus slave
  pertm_bus_st_t st_q;
  pertm_bus_st_t st_d;
  logic [31:0] waddr_q;
  logic [31:0] hrdata_q;
  logic take;
  logic wr_take;
  logic rd_take;
  logic wr_commit;
  logic trans_ok;
  logic size_ok;

  // Timer state
  logic [SYNC_STAGES-1:0] sync_q;
  logic in_level_q;
  logic in_agree;
  logic in_edge;
  logic tick;
  logic run_q;
  logic ie_q;
  logic [2:0] psel_q;
  logic [15:0] reload_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic zero_hit_q;
  logic zero_hit_d;
  logic flag_q;
  logic flag_seen_q;
  logic dec_go;
  logic reload_go;
  logic timeout_ev;
  logic flag_clr;
  logic flag_arm;

  // Interrupt registers
  logic [EV_NUM-1:0] ists_q;
  logic [EV_NUM-1:0] ien_q;
  logic [EV_NUM-1:0] ev;
  logic [EV_NUM-1:0] ev_clr;

  // Write strobes and read data
  logic ctl_wr;
  logic ien_wr;
  logic iclr_wr;
  logic ctl_rd;
  logic [31:0] ctl_word;
  logic [31:0] rd_data;
  logic wr_run;
  logic wr_ie;
  logic [2:0] wr_psel;
  logic wr_flag;
  logic [15:0] wr_reload;
  logic sel_ctl;
  logic sel_cnt;
  logic sel_ists;
  logic sel_ien;

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_a);
    addr_is = a == ref_a;
  endfunction

  // Address phase is taken only for whole-word non-idle transfers
  assign trans_ok = htrans[1];
  assign size_ok = hsize == HSIZE_WORD;
  assign take = hsel & hready & trans_ok & size_ok;
  assign wr_take = take & hwrite;
  assign rd_take = take & ~hwrite;

  // Writes take one wait state so a following read sees the new value
  assign wr_commit = st_q == PERTM_BUS_WWAIT;
  assign hreadyout = st_q != PERTM_BUS_WWAIT;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      PERTM_BUS_IDLE: begin
        if (wr_take) begin
          st_d = PERTM_BUS_WWAIT;
        end
      end
      PERTM_BUS_WWAIT: begin
        st_d = PERTM_BUS_IDLE;
      end
      default: begin
        st_d = PERTM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= PERTM_BUS_IDLE;
      waddr_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      if (wr_take) begin
        waddr_q <= haddr;
      end
    end
  end

  assign ctl_wr = wr_commit & addr_is(waddr_q, ADDR_CTL);
  assign ien_wr = wr_commit & addr_is(waddr_q, ADDR_IEN);
  assign iclr_wr = wr_commit & addr_is(waddr_q, ADDR_ICLR);
  assign ctl_rd = rd_take & sel_ctl;

  // Control fields as they stand in the write data phase
  assign wr_run = hwdata[CTL_RUN_BIT];
  assign wr_ie = hwdata[CTL_IE_BIT];
  assign wr_psel = hwdata[CTL_PS_MSB:CTL_PS_LSB];
  assign wr_flag = hwdata[CTL_STS_BIT];
  assign wr_reload = hwdata[CTL_RLD_MSB:CTL_RLD_LSB];

  // Read selects decode the address phase, not the latched write address
  assign sel_ctl = addr_is(haddr, ADDR_CTL);
  assign sel_cnt = addr_is(haddr, ADDR_CNT);
  assign sel_ists = addr_is(haddr, ADDR_ISTS);
  assign sel_ien = addr_is(haddr, ADDR_IEN);

  // Reserved control bits read as zero
  always_comb begin
    ctl_word = 32'h00000000;
    ctl_word[CTL_RUN_BIT] = run_q;
    ctl_word[CTL_IE_BIT] = ie_q;
    ctl_word[CTL_PS_MSB:CTL_PS_LSB] = psel_q;
    ctl_word[CTL_STS_BIT] = flag_q;
    ctl_word[CTL_RLD_MSB:CTL_RLD_LSB] = reload_q;
  end

  // Unmapped and write-only addresses read as zero
  assign rd_data = sel_ctl ? ctl_word :
                   sel_cnt ? {16'h0000, cnt_q} :
                   sel_ists ? {{(32-EV_NUM){1'b0}}, ists_q} :
                   sel_ien ? {{(32-EV_NUM){1'b0}}, ien_q} :
                   32'h00000000;

  // Read data is captured at the address phase and stands in the data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_q <= rd_data;
    end
  end

  // Input clock: three stages, an edge counts once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= '0;
      in_level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[SYNC_STAGES-2:0], crystal_input};
      if (in_agree) begin
        in_level_q <= sync_q[2];
      end
    end
  end

  assign in_agree = sync_q[1] == sync_q[2];
  assign in_edge = in_agree & sync_q[2] & ~in_level_q;

  pertm_prescaler u_psc (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_edge(in_edge),
    .en(run_q),
    .restart(ctl_wr),
    .psel(psel_q),
    .tick(tick)
  );

  // Control fields; a write to one never touches the flag directly
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= RST_RUN;
      ie_q <= RST_IE;
      psel_q <= RST_PSEL;
      reload_q <= RST_RELOAD;
    end else if (ctl_wr) begin
      run_q <= wr_run;
      ie_q <= wr_ie;
      psel_q <= wr_psel;
      reload_q <= wr_reload;
    end
  end

  // Counting halts entirely while run is clear, reloads included
  assign dec_go = run_q & tick & ~zero_hit_q & ~ctl_wr;
  assign reload_go = run_q & in_edge & zero_hit_q & ~ctl_wr;
  assign timeout_ev = dec_go & (cnt_q == 16'h0001);

  always_comb begin
    cnt_d = cnt_q;
    zero_hit_d = zero_hit_q;
    if (ctl_wr) begin
      // A write aborts the running period and restarts from the new count
      cnt_d = wr_reload;
      zero_hit_d = 1'b0;
    end else if (reload_go) begin
      cnt_d = reload_q;
      zero_hit_d = 1'b0;
    end else if (dec_go) begin
      // Zero loaded wraps to all ones, giving the full 65536-tick period
      cnt_d = cnt_q - 16'h0001;
      zero_hit_d = timeout_ev;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= RST_COUNT;
      zero_hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      zero_hit_q <= zero_hit_d;
    end
  end

  // Flag clears only on a zero write after it was read as one
  assign flag_clr = ctl_wr & ~wr_flag & flag_seen_q;

  // Only a control read that returned the flag as one arms the clear;
  // a read of the live count does not
  assign flag_arm = ctl_rd & flag_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
      flag_seen_q <= 1'b0;
    end else begin
      // Set wins over clear; a second zero while set is simply absorbed
      flag_q <= timeout_ev | (flag_q & ~flag_clr);
      if (flag_clr) begin
        flag_seen_q <= 1'b0;
      end else if (flag_arm) begin
        flag_seen_q <= 1'b1;
      end
    end
  end

  // Enable masks the request only; the counter is unaffected
  assign timer_irq_req = flag_q & ie_q;

  // Event interrupt registers
  assign ev[EV_TIMEOUT] = timeout_ev;
  assign ev[EV_OVERRUN] = timeout_ev & flag_q;

  // Clear mask; an event in the same cycle still wins
  assign ev_clr = iclr_wr ? hwdata[EV_NUM-1:0] : '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ists_q <= '0;
      ien_q <= RST_IEN;
    end else begin
      ists_q <= ev | (ists_q & ~ev_clr);
      if (ien_wr) begin
        ien_q <= hwdata[EV_NUM-1:0];
      end
    end
  end

  assign irq = |(ists_q & ien_q);

endmodule

// ### verification/pertm_properties.sv
// Port checker for the periodic interrupt timer.
// Assumes a lone AHB-Lite slave whose hready is its own hreadyout.
`timescale 1ns/1ps
module pertm_properties
  import pertm_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [1:0] hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic timer_irq_req, // Timer request
  input wire logic irq // Event interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire take = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
  wire rd = take && !hwrite;
  wire wr = take && hwrite;
  wire readable = haddr inside {ADDR_CTL, ADDR_CNT, ADDR_ISTS, ADDR_IEN};
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_write_wait: assert property (wr |=> one_wait)
    else $error("write data phase is not one wait state");
  chk_read_nowait: assert property (rd |=> hreadyout)
    else $error("read data phase stalled");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response is not OKAY");
  chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd && !readable |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctl_reserved: assert property (rd && haddr == ADDR_CTL |=>
    (hrdata & 32'h98FE0000) == 32'h0)
    else $error("control reserved bits not zero");
  chk_count_width: assert property (rd && haddr == ADDR_CNT |=>
    hrdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  chk_req_holds: assert property (timer_irq_req && hreadyout |=> timer_irq_req)
    else $error("request dropped without a write");
  chk_irq_sticky: assert property (irq && hreadyout |=> irq)
    else $error("event interrupt dropped without a write");
endmodule
bind pertm_top pertm_properties i_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hready, .hreadyout, .hresp, .hrdata, .timer_irq_req, .irq);

// ### verification/pertm_xtal_model.sv
// Clock module stand-in: a free-running timer input clock.
// Assumes half is at least 3, so each level lasts at least three system clocks.
`timescale 1ns/1ps
module pertm_xtal_model (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] half, // Clocks per level
  output logic crystal_input // Timer input clock
);
  logic [7:0] cnt_q;
  // Kept far below clk so the timer sees a slow input clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      crystal_input <= 1'b0;
    end else if (cnt_q + 8'h01 >= half) begin
      cnt_q <= 8'h00;
      crystal_input <= ~crystal_input;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ### verification/tb_periodic_interrupt_timer.sv
// Self-checking bench for the periodic interrupt timer.
// Assumes the slave is alone on AHB-Lite and the input clock model is slow.
`timescale 1ns/1ps
module tb_periodic_interrupt_timer
  import pertm_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_ph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] half = 8'h04;
  logic [15:0] r;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rnd = 32'h00015BBC;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int num_errors = 0;
  int checks = 0;
  int n;
  wire hready;
  wire xin;
  wire req;
  wire irq;
  wire [31:0] hrdata;
  always #2.5 clk = ~clk;
  pertm_xtal_model i_pertm_xtal_model (.clk, .sys_rst, .half, .crystal_input(xin));
  pertm_top i_pertm_top (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(HSIZE_WORD), .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata,
    .crystal_input(xin), .timer_irq_req(req), .irq);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] cw(input logic run, ie, input logic [2:0] ps,
    input logic f, input logic [15:0] v);
    return {1'b0, run, ie, 2'h0, ps, 7'h0, f, v};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, e, m);
    eq.push_back(e & m);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // Start just after a falling input edge so no rising edge is in flight
  task automatic ctl(input logic [31:0] d);
    @(negedge xin);
    @(posedge clk);
    bus(1'b1, ADDR_CTL, d);
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_ph && hready) cmp("hrdata", eq.pop_front(), hrdata & mq.pop_front());
    if (hready) rd_ph = hsel && htrans[1] && !hwrite;
  end
  // Roughly ten times the expected run
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTL, 32'h0, ALL);
    rd(ADDR_CNT, 32'h0, ALL);
    $display("test reset done");
    for (int c = 0; c < 5; c++) begin
      rnd = xs(rnd);
      r = {14'h0, rnd[1:0]} + 16'h0001;
      ctl(cw(1'b1, 1'b1, c[2:0], 1'b0, r) | (rnd & 32'h98FE0000));
      n = 0;
      while (req !== 1'b1 && n < 9000) begin
        @(posedge xin);
        #1;
        n++;
      end
      cmp("edges", 32'(r) * (32'h4 << c) + 32'h1, n);
      repeat (6) @(posedge clk);
      rd(ADDR_CNT, 32'(r), ALL);
      bus(1'b1, ADDR_CTL, cw(1'b1, 1'b1, c[2:0], 1'b0, r));
      cmp("timer_irq_req", 32'h1, 32'(req));
      rd(ADDR_CTL, cw(1'b1, 1'b1, c[2:0], 1'b1, r), ALL);
      bus(1'b1, ADDR_CTL, cw(1'b1, 1'b1, c[2:0], 1'b1, r));
      cmp("timer_irq_req", 32'h1, 32'(req));
      bus(1'b1, ADDR_CTL, cw(1'b0, 1'b1, c[2:0], 1'b0, r));
      cmp("timer_irq_req", 32'h0, 32'(req));
    end
    $display("test prescale done");
    half <= 8'h06;
    for (int k = 0; k < 4; k++) begin
      ctl(cw(k != 0, 1'b0, (k == 0) ? 3'h0 : 3'(4 + k), 1'b0, 16'h0005));
      repeat (20) @(posedge xin);
      @(posedge clk);
      rd(ADDR_CNT, 32'h5, ALL);
    end
    half <= 8'h04;
    $display("test hold done");
    ctl(cw(1'b1, 1'b0, 3'h0, 1'b0, 16'h0000));
    repeat (5) @(posedge xin);
    repeat (6) @(posedge clk);
    rd(ADDR_CNT, 32'hFFFF, ALL);
    bus(1'b1, ADDR_IEN, 32'h3);
    ctl(cw(1'b1, 1'b0, 3'h0, 1'b0, 16'h0001));
    repeat (12) @(posedge xin);
    @(posedge clk);
    cmp("timer_irq_req", 32'h0, 32'(req));
    cmp("irq", 32'h1, 32'(irq));
    rd(ADDR_ISTS, 32'h3, ALL);
    rd(ADDR_CTL, cw(1'b1, 1'b0, 3'h0, 1'b1, 16'h0001), ALL);
    bus(1'b1, ADDR_IEN, 32'h0);
    cmp("irq", 32'h0, 32'(irq));
    bus(1'b1, ADDR_CTL, cw(1'b0, 1'b0, 3'h0, 1'b0, 16'h0001));
    bus(1'b1, ADDR_IEN, 32'h3);
    cmp("irq", 32'h1, 32'(irq));
    bus(1'b1, ADDR_ICLR, 32'h3);
    cmp("irq", 32'h0, 32'(irq));
    rd(ADDR_ISTS, 32'h0, ALL);
    $display("test events done");
    bus(1'b1, ADDR_CNT, rnd);
    bus(1'b1, 32'h8007FC48, rnd);
    rd(ADDR_CNT, 32'h1, ALL);
    rd(ADDR_ICLR, 32'h0, ALL);
    rd(32'h8007FC48, 32'h0, ALL);
    $display("test access done");
    @(posedge clk);
    complete_run();
  end
endmodule
